/* rtl/ldcb_pkg.sv */
package ldcb_pkg;

   // ==========================================================
   // Logical device numbers and register indices
   localparam logic [7:0] DEV_UART2 = 8'h02;
   localparam logic [7:0] DEV_PRINTER = 8'h03;
   localparam logic [7:0] DEV_ENV = 8'h04;

   localparam logic [7:0] IDX_ACTIVATE = 8'h30;
   localparam logic [7:0] IDX_BASE0_HI = 8'h60;
   localparam logic [7:0] IDX_BASE0_LO = 8'h61;
   localparam logic [7:0] IDX_BASE1_HI = 8'h62;
   localparam logic [7:0] IDX_BASE1_LO = 8'h63;
   localparam logic [7:0] IDX_IRQ = 8'h70;
   localparam logic [7:0] IDX_DMA = 8'h74;
   localparam logic [7:0] IDX_SPECIAL = 8'hf0;
   localparam logic [7:0] IDX_WAKE_STATUS = 8'hf1;
   localparam logic [7:0] IDX_CARD_PINS = 8'hf2;
   localparam logic [7:0] IDX_CARD_DIV = 8'hf3;

   // ==========================================================
   // Values after reset and writable masks
   localparam logic [7:0] RST_WAKE_EN = 8'h00;
   localparam logic [7:0] RST_WAKE_ST = 8'h00;
   localparam logic [7:0] MASK_WAKE_EN = 8'h5f;
   localparam logic [7:0] MASK_WAKE_EVT = 8'h5f;

   // ==========================================================
   // Field positions
   localparam int BIT_ENABLE = 0;
   localparam int BIT_EPP_EN = 0;
   localparam int BIT_ECP_EN = 1;
   localparam int BIT_IRQ_SHARE = 2;
   localparam int BIT_POST_OFF = 3;
   localparam int BIT_EPP_BLOCK = 2;
   localparam int BIT_CARD_PWR_POL = 2;
   localparam int BIT_CARD_PRES_POL = 7;
   localparam int BIT_STANDBY_LOST = 7;

   localparam int PIN_CARD_DET = 5;
   localparam int PIN_STANDBY_OFF = 6;
   localparam int PIN_MAIN_PREV = 7;

   localparam logic [2:0] UART_MODE_STD = 3'b000;
   localparam logic [2:0] UART_MODE_CARD = 3'b100;

   // ==========================================================
   // Plain configuration storage, one entry per register
   localparam int NUM_CFG = 16;
   localparam int E_CARD_PINS = 0;
   localparam int E_CARD_DIV = 1;
   localparam int E_PRN_ACT = 2;
   localparam int E_PRN_B0_HI = 3;
   localparam int E_PRN_B0_LO = 4;
   localparam int E_PRN_B1_HI = 5;
   localparam int E_PRN_B1_LO = 6;
   localparam int E_PRN_IRQ = 7;
   localparam int E_PRN_DMA = 8;
   localparam int E_PRN_SPECIAL = 9;
   localparam int E_ENV_ACT = 10;
   localparam int E_ENV_B0_HI = 11;
   localparam int E_ENV_B0_LO = 12;
   localparam int E_ENV_B1_HI = 13;
   localparam int E_ENV_B1_LO = 14;
   localparam int E_ENV_IRQ = 15;

   typedef logic [7:0] ldcb_byte_t;
   typedef ldcb_byte_t ldcb_tab_t [NUM_CFG];

   localparam ldcb_tab_t CFG_DEV = '{DEV_UART2, DEV_UART2,
      DEV_PRINTER, DEV_PRINTER, DEV_PRINTER, DEV_PRINTER, DEV_PRINTER,
      DEV_PRINTER, DEV_PRINTER, DEV_PRINTER,
      DEV_ENV, DEV_ENV, DEV_ENV, DEV_ENV, DEV_ENV, DEV_ENV};
   localparam ldcb_tab_t CFG_IDX = '{IDX_CARD_PINS, IDX_CARD_DIV,
      IDX_ACTIVATE, IDX_BASE0_HI, IDX_BASE0_LO, IDX_BASE1_HI, IDX_BASE1_LO,
      IDX_IRQ, IDX_DMA, IDX_SPECIAL,
      IDX_ACTIVATE, IDX_BASE0_HI, IDX_BASE0_LO, IDX_BASE1_HI, IDX_BASE1_LO, IDX_IRQ};
   localparam ldcb_tab_t CFG_RST = '{8'h00, 8'h7f,
      8'h00, 8'h03, 8'h78, 8'h07, 8'h78, 8'h07, 8'h03, 8'h03,
      8'h00, 8'h02, 8'h90, 8'h02, 8'h30, 8'h09};
   localparam ldcb_tab_t CFG_MASK = '{8'h07, 8'hff,
      8'h01, 8'h0f, 8'hfc, 8'h0f, 8'hfc, 8'h0f, 8'h07, 8'h0f,
      8'h01, 8'h0f, 8'hf8, 8'h0f, 8'hf8, 8'h0f};

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      CLK_STOP = 2'b00,
      CLK_3M5 = 2'b01,
      CLK_7M1 = 2'b10,
      CLK_DIVIDED = 2'b11
   } ldcb_card_clk_e;

   typedef struct packed {
      logic [7:0] dev;
      logic [7:0] index;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } ldcb_req_s;

   typedef struct packed {
      logic active;
      logic power_pol;
      ldcb_card_clk_e clk_sel;
      logic [6:0] divisor;
      logic present_pol;
   } ldcb_card_s;

   typedef struct packed {
      logic enable;
      logic [11:0] base0;
      logic [11:0] base1;
      logic [3:0] irq;
      logic [2:0] dma;
      logic post_off;
      logic irq_share;
      logic ecp_en;
      logic epp_en;
   } ldcb_par_s;

   typedef struct packed {
      logic enable;
      logic [11:0] base;
      logic [11:0] wake_base;
      logic [3:0] irq;
   } ldcb_ec_s;

endpackage : ldcb_pkg

/* rtl/ldcb_sync.sv */
`timescale 1ns/1ps
module ldcb_sync (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic ce,
   input wire logic [7:0] async_in,
   output logic [7:0] stable
);
   import ldcb_pkg::*;

   // ==========================================================
   // Three stages per pin; level taken once stages two and three agree
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_pin
         logic s1_q;
         logic s2_q;
         logic s3_q;
         logic lvl_q;
         assign stable[g] = lvl_q;
         always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
               s1_q <= 1'b0;
               s2_q <= 1'b0;
               s3_q <= 1'b0;
               lvl_q <= 1'b0;
            end else if (ce) begin
               s1_q <= async_in[g];
               s2_q <= s1_q;
               s3_q <= s2_q;
               if (s2_q == s3_q) begin
                  lvl_q <= s3_q;
               end
            end
         end
      end
   endgenerate

endmodule : ldcb_sync

/* rtl/ldcb_bank.sv */
//
// Operation
// - Card settings apply only in card mode
// - Index F2h bit 2 sets power polarity
// - Bits 1-0 choose stop, 3.5, 7.1, divided
// - Index F3h holds divisor and presence polarity
// - Printer activate bit 0 enables port
// - Primary base: bits 11:2 writable, rest zero
// - Base low bit 2 forces EPP off
// - Secondary base same layout, own resets
// - Printer interrupt level, four bits
// - Printer DMA channel, three bits
// - Special bit 3 disables boot-progress port
// - Special bit 2 selects interrupt sharing
// - Mode bits: bit 1 ECP, bit 0 EPP
// - Environment activate bit 0 enables controller
// - Environment base: bits 11:3 writable
// - Wake direct base: bits 11:3 writable
// - Environment interrupt level, four bits
// - Standby loss sets bit 7; one clears
// - Wake enable bits per event source
// - Wake status bits report detected events
// - Status bit 7 shows prior main power
// - Card mode is serial mode 100
// - Access input gates wake registers
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
module ldcb_bank (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic ce,
   input wire ldcb_pkg::ldcb_req_s bus_req,
   output logic [7:0] rd_data,
   input wire logic [2:0] uart2_mode,
   input wire logic wake_access_en,
   input wire logic [7:0] wake_pins,
   output ldcb_pkg::ldcb_card_s card_cfg,
   output ldcb_pkg::ldcb_par_s par_cfg,
   output ldcb_pkg::ldcb_ec_s ec_cfg,
   output logic pme_event
);
   import ldcb_pkg::*;

   // ==========================================================
   // Pin synchronisers
   logic [7:0] pin_lvl;

   ldcb_sync u_sync (
      .core_clk(core_clk),
      .reset(reset),
      .ce(ce),
      .async_in(wake_pins),
      .stable(pin_lvl)
   );

   // ==========================================================
   // Plain configuration registers
   logic [7:0] cfg_q [NUM_CFG];
   logic [7:0] rd_chain [NUM_CFG+1];
   logic [NUM_CFG-1:0] cfg_hit;

   assign rd_chain[0] = 8'h00;

   genvar g;
   generate
      for (g = 0; g < NUM_CFG; g++) begin : g_cfg
         logic [7:0] cfg_d;
         assign cfg_hit[g] = (bus_req.dev == CFG_DEV[g]) && (bus_req.index == CFG_IDX[g]);
         // Read-only bits are never stored, so they read zero
         assign cfg_d = (bus_req.wr && cfg_hit[g]) ? (bus_req.wdata & CFG_MASK[g])
                        : cfg_q[g];
         assign rd_chain[g+1] = rd_chain[g] | (cfg_hit[g] ? cfg_q[g] : 8'h00);
         always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
               cfg_q[g] <= CFG_RST[g];
            end else if (ce) begin
               cfg_q[g] <= cfg_d;
            end
         end
      end
   endgenerate

   // ==========================================================
   // Wake event enable and status
   logic [7:0] wen_q;
   logic [7:0] wen_d;
   logic [7:0] wst_q;
   logic [7:0] wst_d;
   logic [7:0] evt_prev_q;
   logic [7:0] evt_lvl;
   logic [7:0] evt_rise;
   logic hit_wen;
   logic hit_wst;
   logic wr_wen;
   logic rd_wst;
   logic standby_off;
   logic clr_lost;

   assign hit_wen = wake_access_en && (bus_req.dev == DEV_ENV)
                    && (bus_req.index == IDX_SPECIAL);
   assign hit_wst = wake_access_en && (bus_req.dev == DEV_ENV)
                    && (bus_req.index == IDX_WAKE_STATUS);
   assign wr_wen = bus_req.wr && hit_wen;
   assign rd_wst = bus_req.rd && hit_wst;

   // Event pins line up with status bits 6 and 4..0
   assign evt_lvl = {1'b0, pin_lvl[PIN_CARD_DET], 1'b0, pin_lvl[4:0]};
   assign evt_rise = evt_lvl & ~evt_prev_q;

   assign standby_off = pin_lvl[PIN_STANDBY_OFF];
   assign clr_lost = wr_wen && bus_req.wdata[BIT_STANDBY_LOST];

   // Set wins over the software clear
   assign wen_d[BIT_STANDBY_LOST] = standby_off
                                    || (wen_q[BIT_STANDBY_LOST] && !clr_lost);
   assign wen_d[6:0] = wr_wen ? (bus_req.wdata[6:0] & MASK_WAKE_EN[6:0])
                       : wen_q[6:0];

   // Read of status clears events; a new event in that cycle wins
   assign wst_d[6:0] = (wst_q[6:0] & ~{7{rd_wst}})
                       | (evt_rise[6:0] & wen_q[6:0] & MASK_WAKE_EVT[6:0]);
   assign wst_d[7] = pin_lvl[PIN_MAIN_PREV];

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         wen_q <= RST_WAKE_EN;
         wst_q <= RST_WAKE_ST;
         evt_prev_q <= 8'h00;
      end else if (ce) begin
         wen_q <= wen_d;
         wst_q <= wst_d;
         evt_prev_q <= evt_lvl;
      end
   end

   // ==========================================================
   // Read path, data in the cycle after the strobe
   logic [7:0] rd_mux;
   logic [7:0] rd_d;

   assign rd_mux = rd_chain[NUM_CFG] | (hit_wen ? wen_q : 8'h00)
                   | (hit_wst ? wst_q : 8'h00);
   assign rd_d = bus_req.rd ? rd_mux : 8'h00;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rd_data <= 8'h00;
      end else if (ce) begin
         rd_data <= rd_d;
      end
   end

   // ==========================================================
   // Smart card settings
   logic card_mode;
   ldcb_card_s card_d;

   assign card_mode = (uart2_mode == UART_MODE_CARD);
   // Outside card mode the pins see reset settings and a stopped clock
   assign card_d.active = card_mode;
   assign card_d.power_pol = card_mode ? cfg_q[E_CARD_PINS][BIT_CARD_PWR_POL]
                             : CFG_RST[E_CARD_PINS][BIT_CARD_PWR_POL];
   assign card_d.clk_sel = card_mode ? ldcb_card_clk_e'(cfg_q[E_CARD_PINS][1:0])
                           : CLK_STOP;
   assign card_d.divisor = card_mode ? cfg_q[E_CARD_DIV][6:0]
                           : CFG_RST[E_CARD_DIV][6:0];
   assign card_d.present_pol = card_mode ? cfg_q[E_CARD_DIV][BIT_CARD_PRES_POL]
                               : CFG_RST[E_CARD_DIV][BIT_CARD_PRES_POL];

   // ==========================================================
   // Printer port settings
   ldcb_par_s par_d;
   logic [7:0] prn_special;

   assign prn_special = cfg_q[E_PRN_SPECIAL];
   assign par_d.enable = cfg_q[E_PRN_ACT][BIT_ENABLE];
   assign par_d.base0 = {cfg_q[E_PRN_B0_HI][3:0], cfg_q[E_PRN_B0_LO]};
   assign par_d.base1 = {cfg_q[E_PRN_B1_HI][3:0], cfg_q[E_PRN_B1_LO]};
   assign par_d.irq = cfg_q[E_PRN_IRQ][3:0];
   assign par_d.dma = cfg_q[E_PRN_DMA][2:0];
   assign par_d.post_off = prn_special[BIT_POST_OFF];
   assign par_d.irq_share = prn_special[BIT_IRQ_SHARE];
   assign par_d.ecp_en = prn_special[BIT_ECP_EN];
   assign par_d.epp_en = prn_special[BIT_EPP_EN]
                         && !cfg_q[E_PRN_B0_LO][BIT_EPP_BLOCK];

   // ==========================================================
   // Environment controller settings and event output
   ldcb_ec_s ec_d;
   logic pme_d;

   assign ec_d.enable = cfg_q[E_ENV_ACT][BIT_ENABLE];
   assign ec_d.base = {cfg_q[E_ENV_B0_HI][3:0], cfg_q[E_ENV_B0_LO]};
   assign ec_d.wake_base = {cfg_q[E_ENV_B1_HI][3:0], cfg_q[E_ENV_B1_LO]};
   assign ec_d.irq = cfg_q[E_ENV_IRQ][3:0];
   assign pme_d = |(wst_q & wen_q & MASK_WAKE_EVT);

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         card_cfg <= '0;
         par_cfg <= '0;
         ec_cfg <= '0;
         pme_event <= 1'b0;
      end else if (ce) begin
         card_cfg <= card_d;
         par_cfg <= par_d;
         ec_cfg <= ec_d;
         pme_event <= pme_d;
      end
   end

   // ==========================================================
   // Checks
   sequence wr_lost_clear;
      ce && clr_lost && !standby_off;
   endsequence

   sequence rd_status;
      ce && rd_wst;
   endsequence

   sequence wr_prn_irq;
      ce && bus_req.wr && cfg_hit[E_PRN_IRQ];
   endsequence

   card_gate_a: assert property (
      @(posedge core_clk) disable iff (reset)
      ce && !card_mode |=> card_cfg.clk_sel == CLK_STOP && !card_cfg.active)
      else $error("card clock runs outside card mode");

   card_pass_a: assert property (
      @(posedge core_clk) disable iff (reset)
      ce && card_mode |=> card_cfg.clk_sel == $past(cfg_q[E_CARD_PINS][1:0])
                          && card_cfg.divisor == $past(cfg_q[E_CARD_DIV][6:0]))
      else $error("card settings not passed in card mode");

   epp_force_a: assert property (
      @(posedge core_clk) disable iff (reset)
      ce |=> par_cfg.epp_en == ($past(prn_special[BIT_EPP_EN])
                                && !$past(cfg_q[E_PRN_B0_LO][BIT_EPP_BLOCK])))
      else $error("EPP enable wrong");

   base_ro_a: assert property (
      @(posedge core_clk) disable iff (reset)
      ce && bus_req.rd && cfg_hit[E_PRN_B0_LO] |=> rd_data[1:0] == 2'b00)
      else $error("read-only base bits not zero");

   irq_write_a: assert property (
      @(posedge core_clk) disable iff (reset)
      wr_prn_irq ##1 ce |=> par_cfg.irq == $past(bus_req.wdata[3:0], 2))
      else $error("printer interrupt level not stored");

   lost_set_a: assert property (
      @(posedge core_clk) disable iff (reset)
      ce && standby_off |=> wen_q[BIT_STANDBY_LOST])
      else $error("standby loss flag not set");

   lost_clear_a: assert property (
      @(posedge core_clk) disable iff (reset)
      wr_lost_clear |=> !wen_q[BIT_STANDBY_LOST])
      else $error("standby loss flag not cleared");

   status_read_a: assert property (
      @(posedge core_clk) disable iff (reset)
      rd_status |=> rd_data == $past(wst_q))
      else $error("status read data wrong");

   access_gate_a: assert property (
      @(posedge core_clk) disable iff (reset)
      ce && bus_req.rd && !wake_access_en && bus_req.dev == DEV_ENV
      && bus_req.index == IDX_WAKE_STATUS |=> rd_data == 8'h00)
      else $error("wake status readable while gated");

   pme_out_a: assert property (
      @(posedge core_clk) disable iff (reset)
      ce |=> pme_event == |($past(wst_q) & $past(wen_q) & MASK_WAKE_EVT))
      else $error("event output mismatch");

   card_pol_a: assert property (
      @(posedge core_clk) disable iff (reset)
      ce && card_mode
      |=> card_cfg.power_pol == $past(cfg_q[E_CARD_PINS][BIT_CARD_PWR_POL]))
      else $error("card power polarity not passed");

   card_pres_a: assert property (
      @(posedge core_clk) disable iff (reset)
      ce && card_mode
      |=> card_cfg.present_pol == $past(cfg_q[E_CARD_DIV][BIT_CARD_PRES_POL]))
      else $error("card presence polarity not passed");

   card_idle_a: assert property (
      @(posedge core_clk) disable iff (reset)
      ce && !card_mode
      |=> card_cfg.divisor == CFG_RST[E_CARD_DIV][6:0]
          && card_cfg.power_pol == CFG_RST[E_CARD_PINS][BIT_CARD_PWR_POL])
      else $error("card settings leak outside card mode");

   par_enable_a: assert property (
      @(posedge core_clk) disable iff (reset)
      ce |=> par_cfg.enable == $past(cfg_q[E_PRN_ACT][BIT_ENABLE]))
      else $error("printer enable not passed");

   ecp_mode_a: assert property (
      @(posedge core_clk) disable iff (reset)
      ce |=> par_cfg.ecp_en == $past(prn_special[BIT_ECP_EN]))
      else $error("ECP enable wrong");

   base1_ro_a: assert property (
      @(posedge core_clk) disable iff (reset)
      ce && bus_req.rd && cfg_hit[E_PRN_B1_LO] |=> rd_data[1:0] == 2'b00)
      else $error("secondary base low bits not zero");

   env_base_a: assert property (
      @(posedge core_clk) disable iff (reset)
      ce && bus_req.rd && cfg_hit[E_ENV_B0_LO] |=> rd_data[2:0] == 3'b000)
      else $error("environment base low bits not zero");

   wake_base_a: assert property (
      @(posedge core_clk) disable iff (reset)
      ce && bus_req.rd && cfg_hit[E_ENV_B1_LO] |=> rd_data[2:0] == 3'b000)
      else $error("wake direct base low bits not zero");

   env_irq_a: assert property (
      @(posedge core_clk) disable iff (reset)
      ce && bus_req.rd && cfg_hit[E_ENV_IRQ] |=> rd_data[7:4] == 4'h0)
      else $error("environment interrupt level upper bits not zero");

   sequence wr_env_irq;
      ce && bus_req.wr && cfg_hit[E_ENV_IRQ];
   endsequence

   env_irq_wr_a: assert property (
      @(posedge core_clk) disable iff (reset)
      wr_env_irq ##1 ce |=> ec_cfg.irq == $past(bus_req.wdata[3:0], 2))
      else $error("environment interrupt level not stored");

   lost_hold_a: assert property (
      @(posedge core_clk) disable iff (reset)
      ce && wen_q[BIT_STANDBY_LOST] && !clr_lost |=> wen_q[BIT_STANDBY_LOST])
      else $error("standby loss flag dropped without a clear");

   status_main_a: assert property (
      @(posedge core_clk) disable iff (reset)
      ce |=> wst_q[7] == $past(pin_lvl[PIN_MAIN_PREV]))
      else $error("prior main power bit wrong");

   status_new_a: assert property (
      @(posedge core_clk) disable iff (reset)
      ce |=> (wst_q[6:0] & ~$past(wst_q[6:0]) & ~$past(wen_q[6:0])) == 7'h00)
      else $error("disabled event source sets status");

   status_clear_a: assert property (
      @(posedge core_clk) disable iff (reset)
      rd_status ##0 !(|(evt_rise & wen_q)) |=> wst_q[6:0] == 7'h00)
      else $error("status not cleared by read");

endmodule : ldcb_bank

/* tb/ldcb_host.sv */
`timescale 1ns/1ps
// ==========================================================
// Host side of the configuration index space
module ldcb_host (
   input wire logic core_clk,
   output ldcb_pkg::ldcb_req_s bus_req,
   input wire logic [7:0] rd_data
);
   import ldcb_pkg::*;

   initial bus_req = '0;

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk);
      bus_req <= '{dev: a[15:8], index: a[7:0], wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      bus_req.wr <= 1'b0;
      // Stale data must not look valid
      bus_req.wdata <= ~d;
   endtask : wr

   // Data taken mid-cycle after the strobe, then the cycle after
   task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic [7:0] nx);
      @(posedge core_clk);
      bus_req <= '{dev: a[15:8], index: a[7:0], wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      bus_req.rd <= 1'b0;
      @(negedge core_clk);
      d = rd_data;
      @(negedge core_clk);
      nx = rd_data;
   endtask : rd
endmodule : ldcb_host

/* tb/ldcb_bank_tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
// ==========================================================
// Self-checking bench with a register mirror
module ldcb_bank_tb;
   import ldcb_pkg::*;
   localparam int NR = 18;
   logic core_clk;
   logic reset = 1'b1;
   logic ce = 1'b1;
   logic [2:0] uart2_mode = 3'b000;
   logic wake_access_en = 1'b1;
   logic [7:0] wake_pins = 8'h00;
   ldcb_req_s bus_req;
   logic [7:0] rd_data;
   ldcb_card_s card_cfg;
   ldcb_par_s par_cfg;
   ldcb_ec_s ec_cfg;
   logic pme_event;
   int errors = 0;
   int cmp_count = 0;
   int k;
   logic [31:0] seed = 32'hed3c;
   logic [31:0] r;
   logic [15:0] ta [NR] = '{16'h02f2, 16'h02f3, 16'h0330, 16'h0360, 16'h0361, 16'h0362,
      16'h0363, 16'h0370, 16'h0374, 16'h03f0, 16'h0430, 16'h0460, 16'h0461, 16'h0462,
      16'h0463, 16'h0470, 16'h04f0, 16'h04f1};
   logic [7:0] tr [NR] = '{8'h00, 8'h7f, 8'h00, 8'h03, 8'h78, 8'h07, 8'h78, 8'h07, 8'h03,
      8'h03, 8'h00, 8'h02, 8'h90, 8'h02, 8'h30, 8'h09, 8'h00, 8'h00};
   logic [7:0] tm [NR] = '{8'h07, 8'hff, 8'h01, 8'h0f, 8'hfc, 8'h0f, 8'hfc, 8'h0f, 8'h07,
      8'h0f, 8'h01, 8'h0f, 8'hf8, 8'h0f, 8'hf8, 8'h0f, 8'h5f, 8'h00};
   logic [7:0] mv [NR];

   ldcb_host i_host (.core_clk(core_clk), .bus_req(bus_req), .rd_data(rd_data));

   ldcb_bank i_dut (
      .core_clk(core_clk),
      .reset(reset),
      .ce(ce),
      .bus_req(bus_req),
      .rd_data(rd_data),
      .uart2_mode(uart2_mode),
      .wake_access_en(wake_access_en),
      .wake_pins(wake_pins),
      .card_cfg(card_cfg),
      .par_cfg(par_cfg),
      .ec_cfg(ec_cfg),
      .pme_event(pme_event)
   );

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   task automatic conclude();
      $display("errors %0d comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : conclude

   // Read and compare, then expect the idle value
   task automatic rdc(input logic [15:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic [7:0] nx;
      i_host.rd(a, d, nx);
      `CHK(d, e)
      `CHK(nx, 8'h00)
   endtask : rdc

   task automatic wrm(input int i, input logic [7:0] v);
      i_host.wr(ta[i], v);
      mv[i] = v & tm[i];
   endtask : wrm

   // ==========================================================
   // Expected configuration outputs from the mirror
   task automatic chk_cfg();
      ldcb_card_s xc;
      ldcb_par_s xp;
      ldcb_ec_s xe;
      xc = (uart2_mode == 3'b100) ? ldcb_card_s'({1'b1, mv[0][2:0], mv[1][6:0], mv[1][7]})
         : ldcb_card_s'(12'h0fe);
      xp = ldcb_par_s'({mv[2][0], mv[3][3:0], mv[4], mv[5][3:0], mv[6], mv[7][3:0],
         mv[8][2:0], mv[9][3:1], mv[9][0] & ~mv[4][2]});
      xe = ldcb_ec_s'({mv[10][0], mv[11][3:0], mv[12], mv[13][3:0], mv[14], mv[15][3:0]});
      repeat (3) @(negedge core_clk);
      `CHK(card_cfg, xc)
      `CHK(par_cfg, xp)
      `CHK(ec_cfg, xe)
   endtask : chk_cfg

   // Raise a wake pin, check event and status, then drop it
   task automatic pulse(input logic [7:0] p, input logic [7:0] e, input logic pm);
      @(posedge core_clk) wake_pins <= p;
      repeat (8) @(negedge core_clk);
      `CHK(pme_event, pm)
      rdc(16'h04f1, e);
      @(posedge core_clk) wake_pins <= 8'h00;
      repeat (8) @(negedge core_clk);
   endtask : pulse

   initial begin
      #250000;
      errors++;
      conclude();
   end

   // ==========================================================
   // Main sequence
   initial begin
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
      for (int i = 0; i < NR; i++) mv[i] = tr[i];
      for (int i = 0; i < NR; i++) rdc(ta[i], tr[i]);
      chk_cfg();
      for (int n = 0; n < 60; n++) begin
         r = xs();
         k = int'(r[3:0]);
         @(posedge core_clk) uart2_mode <= r[8] ? 3'b100 : r[11:9];
         wrm(k, r[23:16]);
         rdc(ta[k], mv[k]);
         chk_cfg();
      end
      wrm(4, 8'h7c);
      wrm(9, 8'h03);
      chk_cfg();
      wrm(4, 8'h78);
      chk_cfg();
      @(posedge core_clk) ce <= 1'b0;
      i_host.wr(ta[7], ~mv[7] & 8'h0f);
      @(posedge core_clk) ce <= 1'b1;
      rdc(ta[7], mv[7]);
      i_host.wr(16'h0531, 8'h55);
      rdc(16'h0531, 8'h00);
      i_host.wr(16'h04f1, 8'hff);
      rdc(16'h04f1, 8'h00);
      i_host.wr(16'h04f0, 8'h41);
      pulse(8'h01, 8'h01, 1'b1);
      rdc(16'h04f1, 8'h00);
      pulse(8'h02, 8'h00, 1'b0);
      pulse(8'h20, 8'h40, 1'b1);
      pulse(8'h80, 8'h80, 1'b0);
      pulse(8'h40, 8'h00, 1'b0);
      rdc(16'h04f0, 8'hc1);
      i_host.wr(16'h04f0, 8'h41);
      rdc(16'h04f0, 8'hc1);
      i_host.wr(16'h04f0, 8'hc1);
      rdc(16'h04f0, 8'h41);
      @(posedge core_clk) wake_access_en <= 1'b0;
      i_host.wr(16'h04f0, 8'h00);
      rdc(16'h04f0, 8'h00);
      @(posedge core_clk) wake_access_en <= 1'b1;
      rdc(16'h04f0, 8'h41);
      conclude();
   end
endmodule : ldcb_bank_tb
